// ### adr_converter_top.sv
// Top of the converter control block: bus slave, registers, interrupt and result path
// Summary of operation
// - Single-ended result is unsigned 10-bit code
// - Differential result is 10-bit two's complement
// - Result top bit is sign when differential
// - Result stored in the same cycle the done flag rises
// - High register holds upper bits, low lower
// - Reference field: external, supply, reserved, internal
// - Reference and channel changes wait for conversion end
// - Internal reference powers on when enabled with the internal reference selected
// - Alignment bit selects left or right adjust
// - Alignment change remaps result registers immediately
// - Channel field selects inputs, amplifiers, bandgap, ground
// - Input select layout: ref, align, unused, channel
// - Input short bit ties differential inputs together
// - Low read locks results until high read
`timescale 1ns/1ns
module adr_converter_top
  import adr_pkg::*;
#(
  parameter int ADDR_W = 8 // Byte address width
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq_o,
  // Analog core side
  input wire logic core_done_i,
  input wire logic [9:0] core_code_i,
  output logic core_start_o,
  output logic converter_enable_o,
  output logic [1:0] reference_select_o,
  output logic [3:0] channel_select_o,
  output logic internal_ref_on_o,
  output logic amplifier_input_short_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] input_select_register; // Reference, alignment, channel
  logic [7:0] control; // Enable and input short; start reads as busy
  logic [7:0] irq_mask; // Interrupt mask, status layout
  logic conversion_done_flag; // Sticky done, read clears
  logic start_pulse; // One-cycle start request
  logic short_q; // Amplifier input short
  logic req; // New bus request this cycle
  logic wr; // Register write this cycle
  logic rd; // Register read this cycle
  logic [7:0] addr; // Byte address, low bits
  logic [7:0] next_rdata; // Read mux output
  logic [7:0] status_view; // Status as read
  logic seq_busy; // Conversion running
  logic seq_done; // Conversion finished pulse
  logic [9:0] seq_code; // Formatted result
  logic [1:0] ref_applied; // Reference in use
  logic [3:0] channel_applied; // Channel in use
  logic core_start_q; // Registered start to core
  logic ref_on_q; // Registered internal reference enable
  logic enable_q; // Registered enable

  adr_result_if res(); // Result path

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // One request per ack; the ack cycle itself is a gap so no double take
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Registers are eight bits wide and live in byte lane 0
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign addr = 8'(wb_adr_i);

  // Acknowledge every request one cycle later, mapped or not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Input select register

  // Bit 4 is unused and always reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      input_select_register <= ADR_INPUT_SELECT_RESET;
    end else if (wr && addr == ADR_OFF_INPUT_SELECT) begin
      input_select_register <= wb_dat_i[7:0] & 8'hEF;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control register

  // Enable and short are plain storage bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control <= ADR_CONTROL_RESET;
    end else if (wr && addr == ADR_OFF_CONTROL) begin
      control <= wb_dat_i[7:0];
    end
  end

  // Start is a write-one strobe; writing zero does nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= wr && addr == ADR_OFF_CONTROL && wb_dat_i[ADR_CTRL_START_POS];
    end
  end

  // Short is registered once, then driven to the amplifier inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      short_q <= 1'b0;
    end else begin
      short_q <= control[ADR_CTRL_SHORT_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt mask and sticky status

  // Mask shares the status layout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= ADR_IRQ_MASK_RESET;
    end else if (wr && addr == ADR_OFF_IRQ_MASK) begin
      irq_mask <= wb_dat_i[7:0];
    end
  end

  // A done in the clearing cycle survives: set wins over the read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conversion_done_flag <= 1'b0;
    end else if (seq_done) begin
      conversion_done_flag <= 1'b1;
    end else if (rd && addr == ADR_OFF_STATUS) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Busy is live state, not sticky
  always_comb begin
    status_view = 8'h00;
    status_view[ADR_STAT_DONE_POS] = conversion_done_flag;
    status_view[ADR_STAT_BUSY_POS] = seq_busy;
  end

  // Level interrupt, only the sticky done bit can raise it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= conversion_done_flag && irq_mask[ADR_STAT_DONE_POS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data

  // Unmapped addresses read zero
  always_comb begin
    case (addr)
      ADR_OFF_INPUT_SELECT: next_rdata = input_select_register;
      ADR_OFF_CONTROL: begin
        next_rdata = control;
        next_rdata[ADR_CTRL_START_POS] = seq_busy;
      end
      ADR_OFF_STATUS: next_rdata = status_view;
      ADR_OFF_IRQ_MASK: next_rdata = irq_mask;
      ADR_OFF_RESULT_LOW: next_rdata = res.low_q;
      ADR_OFF_RESULT_HIGH: next_rdata = res.high_q;
      default: next_rdata = 8'h00;
    endcase
  end

  // Data sampled with the request and held with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_o <= {24'h00_0000, next_rdata};
    end else if (wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result path

  // Alignment acts on the view, never on the stored code
  assign res.capture = seq_done;
  assign res.code = seq_code;
  assign res.left_align = input_select_register[ADR_ALIGN_POS];
  assign res.low_read = rd && addr == ADR_OFF_RESULT_LOW;
  assign res.high_read = rd && addr == ADR_OFF_RESULT_HIGH;

  adr_result_store u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .res(res)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer

  adr_conv_seq u_seq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(control[ADR_CTRL_ENABLE_POS]),
    .start_i(start_pulse),
    .ref_sel_i(input_select_register[ADR_REF_MSB:ADR_REF_LSB]),
    .channel_i(input_select_register[ADR_CH_MSB:0]),
    .core_done_i(core_done_i),
    .core_code_i(core_code_i),
    .busy_o(seq_busy),
    .done_o(seq_done),
    .code_o(seq_code),
    .core_start_o(core_start_q),
    .ref_applied_o(ref_applied),
    .channel_applied_o(channel_applied),
    .internal_ref_on_o(ref_on_q),
    .enable_o(enable_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs, all from flops

  // Applied settings reach the mux and reference switch unchanged
  assign core_start_o = core_start_q;
  assign converter_enable_o = enable_q;
  assign reference_select_o = ref_applied;
  assign channel_select_o = channel_applied;
  assign internal_ref_on_o = ref_on_q;
  assign amplifier_input_short_o = short_q;

endmodule // adr_converter_top

// ### adr_pkg.sv
// Package of register offsets, field layouts, codes and helpers for the converter control block
package adr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus
  localparam logic [7:0] ADR_OFF_INPUT_SELECT = 8'h00; // Reference, alignment, channel
  localparam logic [7:0] ADR_OFF_CONTROL = 8'h04; // Enable, start, input short
  localparam logic [7:0] ADR_OFF_STATUS = 8'h08; // Sticky done flag, busy
  localparam logic [7:0] ADR_OFF_IRQ_MASK = 8'h0C; // Same layout as status
  localparam logic [7:0] ADR_OFF_RESULT_LOW = 8'h10; // Result low byte
  localparam logic [7:0] ADR_OFF_RESULT_HIGH = 8'h14; // Result high byte

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] ADR_INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] ADR_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ADR_IRQ_MASK_RESET = 8'h00;
  localparam logic [9:0] ADR_RESULT_RESET = 10'h000;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int ADR_REF_MSB = 7; // Reference field 7:6
  localparam int ADR_REF_LSB = 6;
  localparam int ADR_ALIGN_POS = 5; // Left align bit
  localparam int ADR_CH_MSB = 3; // Channel field 3:0
  localparam int ADR_CTRL_ENABLE_POS = 0;
  localparam int ADR_CTRL_START_POS = 1;
  localparam int ADR_CTRL_SHORT_POS = 2;
  localparam int ADR_STAT_DONE_POS = 0;
  localparam int ADR_STAT_BUSY_POS = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Reference and channel codes
  localparam logic [1:0] ADR_REF_EXTERNAL = 2'h0; // External pin, internal off
  localparam logic [1:0] ADR_REF_SUPPLY = 2'h1; // Analog supply
  localparam logic [1:0] ADR_REF_RESERVED = 2'h2; // Reserved
  localparam logic [1:0] ADR_REF_INTERNAL = 2'h3; // Internal 2.56V
  localparam logic [3:0] ADR_CH_LAST_SINGLE = 4'hA; // Inputs 0..10
  localparam logic [3:0] ADR_CH_AMPLIFIER_ZERO_INPUT = 4'hB; // Amplifier 0
  localparam logic [3:0] ADR_CH_AMPLIFIER_ONE_INPUT = 4'hC; // Amplifier 1
  localparam logic [3:0] ADR_CH_RESERVED = 4'hD;
  localparam logic [3:0] ADR_CH_BANDGAP = 4'hE;
  localparam logic [3:0] ADR_CH_GROUND = 4'hF;

  // Sequencer states
  typedef enum logic [0:0] {ADR_SEQ_IDLE, ADR_SEQ_CONVERT} adr_seq_state_type;

  // True for the two amplified (differential) channels
  function automatic logic adr_is_differential(input logic [3:0] ch);
    return (ch == ADR_CH_AMPLIFIER_ZERO_INPUT) || (ch == ADR_CH_AMPLIFIER_ONE_INPUT);
  endfunction

  // Maps a 10-bit result onto {high, low} bytes for either alignment
  function automatic logic [15:0] adr_align(input logic [9:0] code, input logic left);
    if (left) begin
      return {code, 6'h00};
    end
    return {6'h00, code};
  endfunction

endpackage

// ### adr_result_if.sv
// Interface carrying the result path between the control top and the result store
`timescale 1ns/1ns
interface adr_result_if;
  logic capture; // Pulse: new result available
  logic [9:0] code; // Formatted 10-bit result
  logic left_align; // Live alignment bit
  logic low_read; // Pulse: low byte read
  logic high_read; // Pulse: high byte read
  logic [7:0] high_q; // High byte view
  logic [7:0] low_q; // Low byte view
  logic locked; // Updates blocked
  modport ctrl(output capture, output code, output left_align, output low_read,
    output high_read, input high_q, input low_q, input locked);
  modport store(input capture, input code, input left_align, input low_read,
    input high_read, output high_q, output low_q, output locked);
endinterface

// ### adr_result_store.sv
// Result store with read lock and live alignment mapping
`timescale 1ns/1ns
module adr_result_store
  import adr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  adr_result_if.store res
);

  logic [9:0] code_q; // Stored result, kept unaligned
  logic locked_q; // Low read seen, high not yet
  logic [15:0] view; // Aligned byte view

  ////////////////////////////////////////////////////////////////////////////////
  // Capture a new result unless a split read is in progress
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code_q <= ADR_RESULT_RESET;
    end else if (res.capture && !locked_q) begin
      code_q <= res.code;
    end
  end

  // Lock after a low read, release on the high read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_q <= 1'b0;
    end else if (res.high_read) begin
      locked_q <= 1'b0;
    end else if (res.low_read) begin
      locked_q <= 1'b1;
    end
  end

  // Alignment applied on the view, so a flip shows at once
  assign view = adr_align(code_q, res.left_align);
  assign res.high_q = view[15:8];
  assign res.low_q = view[7:0];
  assign res.locked = locked_q;

endmodule // adr_result_store

// ### adr_conv_seq.sv
// Conversion sequencer facing the analog core
`timescale 1ns/1ns
module adr_conv_seq
  import adr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic [1:0] ref_sel_i,
  input wire logic [3:0] channel_i,
  input wire logic core_done_i,
  input wire logic [9:0] core_code_i,
  output logic busy_o,
  output logic done_o,
  output logic [9:0] code_o,
  output logic core_start_o,
  output logic [1:0] ref_applied_o,
  output logic [3:0] channel_applied_o,
  output logic internal_ref_on_o,
  output logic enable_o
);

  adr_seq_state_type state; // Sequencer state
  logic [2:0] done_sync; // Done pin synchroniser plus edge stage
  logic [9:0] code_meta; // First stage of code synchroniser
  logic [9:0] code_sync; // Second stage of code synchroniser
  logic done_edge; // Rising edge of the synchronised done

  ////////////////////////////////////////////////////////////////////////////////
  // Core outputs are asynchronous to us; two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_sync <= 3'h0;
      code_meta <= 10'h000;
      code_sync <= 10'h000;
    end else begin
      done_sync <= {done_sync[1:0], core_done_i};
      code_meta <= core_code_i;
      code_sync <= code_meta;
    end
  end
  assign done_edge = done_sync[1] && !done_sync[2];

  // State, start pulse and done pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ADR_SEQ_IDLE;
      core_start_o <= 1'b0;
      done_o <= 1'b0;
      code_o <= ADR_RESULT_RESET;
    end else begin
      core_start_o <= 1'b0;
      done_o <= 1'b0;
      case (state)
        ADR_SEQ_IDLE: begin
          // Start ignored while disabled
          if (start_i && enable_i) begin
            state <= ADR_SEQ_CONVERT;
            core_start_o <= 1'b1;
          end
        end
        ADR_SEQ_CONVERT: begin
          if (done_edge) begin
            state <= ADR_SEQ_IDLE;
            done_o <= 1'b1;
            // Core gives offset binary on differential inputs
            if (adr_is_differential(channel_applied_o)) begin
              code_o <= {~code_sync[9], code_sync[8:0]};
            end else begin
              code_o <= code_sync;
            end
          end
        end
        default: begin
          state <= ADR_SEQ_IDLE;
        end
      endcase
    end
  end

  // Settings follow the register only between conversions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_applied_o <= ADR_REF_EXTERNAL;
      channel_applied_o <= 4'h0;
    end else if (state == ADR_SEQ_IDLE && !(start_i && enable_i)) begin
      ref_applied_o <= ref_sel_i;
      channel_applied_o <= channel_i;
    end
  end

  // Disable takes effect only once the conversion ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_o <= 1'b0;
      internal_ref_on_o <= 1'b0;
    end else begin
      if (enable_i || state == ADR_SEQ_IDLE) begin
        enable_o <= enable_i;
      end
      internal_ref_on_o <= (enable_i || state != ADR_SEQ_IDLE) &&
        (ref_sel_i == ADR_REF_INTERNAL || ref_applied_o == ADR_REF_INTERNAL);
    end
  end

  assign busy_o = (state == ADR_SEQ_CONVERT);

endmodule // adr_conv_seq

// ### adr_converter_asserts.sv
// Port-level checker for the converter control block
`timescale 1ns/1ns
module adr_converter_asserts
  import adr_pkg::*;
#(
  parameter int ADDR_W = 8 // Byte address width
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic core_done_i,
  input wire logic [9:0] core_code_i,
  input wire logic core_start_o,
  input wire logic converter_enable_o,
  input wire logic [1:0] reference_select_o,
  input wire logic [3:0] channel_select_o,
  input wire logic internal_ref_on_o,
  input wire logic amplifier_input_short_o
);
  logic conv; // Core busy, from start pulse to finish edge

  ////////////////////////////////////////////////////////////////////////////////
  // Span of one conversion as seen on the core pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv <= 1'b0;
    end else if (core_start_o) begin
      conv <= 1'b1;
    end else if (core_done_i) begin
      conv <= 1'b0;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer timing
  ack_on_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // Core side
  sel_hold_a: assert property (
    conv && $past(conv) |-> $stable(reference_select_o) && $stable(channel_select_o))
    else $error("selection moved mid conversion");
  start_pulse_a: assert property (core_start_o |=> !core_start_o)
    else $error("start pulse too long");
  one_conv_a: assert property (conv |-> !core_start_o)
    else $error("start while converting");
  int_ref_a: assert property (
    (converter_enable_o && reference_select_o == ADR_REF_INTERNAL) [*2] |-> internal_ref_on_o)
    else $error("internal reference off");
  short_src_a: assert property (
    $changed(amplifier_input_short_o) |-> (wb_we_i && wb_ack_o) ||
    $past(wb_we_i && wb_ack_o) || $past(wb_we_i && wb_ack_o, 2))
    else $error("short changed without write");
endmodule // adr_converter_asserts

bind adr_converter_top adr_converter_asserts #(.ADDR_W(ADDR_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .core_done_i(core_done_i), .core_code_i(core_code_i),
  .core_start_o(core_start_o), .converter_enable_o(converter_enable_o),
  .reference_select_o(reference_select_o), .channel_select_o(channel_select_o),
  .internal_ref_on_o(internal_ref_on_o), .amplifier_input_short_o(amplifier_input_short_o));

// ### adr_core_model.sv
// Behavioural model of the analog converter core
`timescale 1ns/1ns
module adr_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i, // Start pulse from the block
  input wire logic [9:0] raw_i, // Code to report next
  input wire logic slow_i, // Long conversion time
  output logic done_o,
  output logic [9:0] code_o
);
  int cnt; // Cycles left in conversion
  int hold; // Cycles left with done high

  ////////////////////////////////////////////////////////////////////////////////
  // Code is set at start, well before done, so the block sees it settled
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      code_o <= 10'h155;
    end else if (start_i && cnt == 0 && hold == 0) begin
      code_o <= raw_i;
      cnt <= slow_i ? 40 : 5;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (hold == 1) begin
      code_o <= ~code_o; // Released code is not left looking valid
    end
  end

  // Done rises at the end and falls before any next conversion
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      hold <= 0;
    end else if (cnt == 1) begin
      done_o <= 1'b1;
      hold <= 3;
    end else if (hold > 0) begin
      hold <= hold - 1;
      done_o <= hold > 1;
    end
  end
endmodule // adr_core_model

// ### adr_converter_top_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/1ns
module adr_converter_top_tb;
  import adr_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, core_done_i, core_start_o;
  logic converter_enable_o, internal_ref_on_o, amplifier_input_short_o, slow;
  logic [7:0] wb_adr_i, ctrl;
  logic [3:0] wb_sel_i, sel_v, channel_select_o;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [9:0] core_code_i, raw;
  logic [1:0] reference_select_o;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int failures, comparisons;

  adr_converter_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .core_done_i(core_done_i),
    .core_code_i(core_code_i), .core_start_o(core_start_o),
    .converter_enable_o(converter_enable_o), .reference_select_o(reference_select_o),
    .channel_select_o(channel_select_o), .internal_ref_on_o(internal_ref_on_o),
    .amplifier_input_short_o(amplifier_input_short_o));
  adr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .start_i(core_start_o), .raw_i(raw),
    .slow_i(slow), .done_o(core_done_i), .code_o(core_code_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Match each read answer with the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("[FAIL] %0t read answer with no note", $time);
      end else begin
        check(wb_dat_o, exp_q.pop_front());
      end
    end
  end

  // Classic single cycle, held until ack, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sel_v;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, ($urandom() & 32'hFFFFFF00) | {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  // Expected {high, low} bytes for either alignment
  function automatic logic [15:0] fmt(input logic [9:0] c, input logic left);
    return left ? {c, 6'h00} : {6'h00, c};
  endfunction

  // Expected stored code: amplified channels give two's complement
  function automatic logic [9:0] cv(input logic [3:0] ch, input logic [9:0] r);
    return (ch == ADR_CH_AMPLIFIER_ZERO_INPUT || ch == ADR_CH_AMPLIFIER_ONE_INPUT) ? {~r[9], r[8:0]} : r;
  endfunction

  task automatic res(input logic [9:0] c, input logic left);
    logic [15:0] f;
    f = fmt(c, left);
    rd(ADR_OFF_RESULT_LOW, {24'h0, f[7:0]});
    rd(ADR_OFF_RESULT_HIGH, {24'h0, f[15:8]});
  endtask

  task automatic waitirq;
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check(irq_o, 1'b1);
    rd(ADR_OFF_STATUS, 32'h1);
  endtask

  task automatic conv(input logic [3:0] ch, input logic [9:0] r, input logic s);
    raw <= r;
    slow <= s;
    wr(ADR_OFF_INPUT_SELECT, {ADR_REF_SUPPLY, 2'h0, ch});
    wr(ADR_OFF_CONTROL, ctrl | 8'h03);
    waitirq();
  endtask

  task automatic results;
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int i;
    logic [9:0] a, b;
    logic [15:0] f;
    {rst_i, sel_v} = 5'h1F;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {raw, slow, ctrl, failures, comparisons} = '0;
    void'($urandom(32'h2d2a6838));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_OFF_INPUT_SELECT, 32'h0);
    wr(ADR_OFF_INPUT_SELECT, 8'hFF);
    rd(ADR_OFF_INPUT_SELECT, 32'hEF);
    sel_v = 4'hE;
    wr(ADR_OFF_INPUT_SELECT, 8'h00);
    sel_v = 4'hF;
    rd(ADR_OFF_INPUT_SELECT, 32'hEF);
    wr(8'h40, 8'hFF);
    rd(8'h40, 32'h0);
    $display("test registers done");
    for (i = 0; i < 64; i++) begin
      wr(ADR_OFF_INPUT_SELECT, {i[5:4], 1'($urandom()), 1'b0, i[3:0]});
      repeat (3) @(posedge clk_i);
      check(reference_select_o, i[5:4]);
      check(channel_select_o, i[3:0]);
      check(internal_ref_on_o, 1'b0);
    end
    ctrl = 8'h01;
    wr(ADR_OFF_CONTROL, ctrl);
    wr(ADR_OFF_IRQ_MASK, 8'h01);
    repeat (3) @(posedge clk_i);
    check(internal_ref_on_o, 1'b1);
    check(converter_enable_o, 1'b1);
    $display("test selection codes done");
    for (i = 0; i < 16; i++) begin
      a = (i >= 10 && i <= 13) ? {10{i[0]}} : 10'($urandom());
      conv(i[3:0], a, i[0]);
      res(cv(i[3:0], a), 1'b0);
      wr(ADR_OFF_INPUT_SELECT, {ADR_REF_SUPPLY, 1'b1, 1'b0, i[3:0]});
      res(cv(i[3:0], a), 1'b1);
    end
    $display("test conversions done");
    a = 10'($urandom());
    raw <= a;
    slow <= 1'b1;
    wr(ADR_OFF_INPUT_SELECT, {ADR_REF_SUPPLY, 2'h0, 4'h2});
    wr(ADR_OFF_CONTROL, ctrl | 8'h03);
    wr(ADR_OFF_INPUT_SELECT, {ADR_REF_INTERNAL, 2'h0, 4'h5});
    wr(ADR_OFF_CONTROL, ctrl | 8'h03);
    check(reference_select_o, ADR_REF_SUPPLY);
    check(channel_select_o, 4'h2);
    rd(ADR_OFF_STATUS, 32'h2);
    waitirq();
    repeat (2) @(posedge clk_i);
    check(reference_select_o, ADR_REF_INTERNAL);
    check(channel_select_o, 4'h5);
    res(a, 1'b0);
    $display("test held selection done");
    conv(4'h1, a, 1'b0);
    f = fmt(a, 1'b0);
    rd(ADR_OFF_RESULT_LOW, {24'h0, f[7:0]});
    b = ~a;
    conv(4'h1, b, 1'b0);
    rd(ADR_OFF_RESULT_HIGH, {24'h0, f[15:8]});
    rd(ADR_OFF_RESULT_LOW, {24'h0, f[7:0]});
    rd(ADR_OFF_RESULT_HIGH, {24'h0, f[15:8]});
    conv(4'h1, b, 1'b0);
    res(b, 1'b0);
    $display("test result lock done");
    wr(ADR_OFF_IRQ_MASK, 8'h00);
    wr(ADR_OFF_CONTROL, ctrl | 8'h03);
    i = 0;
    while (core_done_i !== 1'b1 && i < 100) begin
      @(posedge clk_i);
      i++;
    end
    repeat (8) @(posedge clk_i);
    check(irq_o, 1'b0);
    wr(ADR_OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b1);
    rd(ADR_OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    check(irq_o, 1'b0);
    $display("test interrupt done");
    wr(ADR_OFF_CONTROL, 8'h05);
    repeat (2) @(posedge clk_i);
    check(amplifier_input_short_o, 1'b1);
    wr(ADR_OFF_CONTROL, 8'h01);
    repeat (2) @(posedge clk_i);
    check(amplifier_input_short_o, 1'b0);
    $display("test input short done");
    results();
  end

  // Cut a hang short well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
endmodule // adr_converter_top_tb
